/* logic/mppt_pkg.sv */
// Package: register map and field layout of the microcontroller pin takeover
package mppt_pkg;
  // Register addresses on the microcontroller memory bus
  localparam logic [15:0] ADDR_STATUS  = 16'h7F3A;
  localparam logic [15:0] ADDR_CONTROL = 16'h7F3B;
  localparam logic [15:0] ADDR_DATA    = 16'h7F3C;
  // Reset values
  localparam logic [7:0]  RST_STATUS   = 8'h00;
  localparam logic [7:0]  RST_CONTROL  = 8'h00;
  localparam logic [7:0]  RST_DATA     = 8'h00;
  // Status field positions
  localparam int ST_OWNER   = 0;
  localparam int ST_FAULT   = 3;
  localparam int ST_SELECT  = 4;
  localparam int ST_PAPER   = 5;
  localparam int ST_ACK     = 6;
  localparam int ST_BUSY    = 7;
  // Control field positions
  localparam int CT_STROBE  = 0;
  localparam int CT_LINEFD  = 1;
  localparam int CT_INIT    = 2;
  localparam int CT_SELIN   = 3;
  localparam int CT_DIR     = 5;
  // Control bits that hold storage (others read zero)
  localparam logic [7:0]  CT_MASK      = 8'h2F;
endpackage : mppt_pkg

/* logic/mppt_top.sv */
// Pin multiplexer letting the microcontroller take over the parallel port
`timescale 1ns/1ps
`default_nettype none
module mppt_top (
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       NRST_I,
  // Microcontroller memory bus
  input  wire logic [15:0] ADDR_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic [7:0] WDATA_I,
  output logic      [7:0] RDATA_O,
  // Host-side port logic
  input  wire logic       HOST_STROBE_I,
  input  wire logic       HOST_LINEFD_I,
  input  wire logic       HOST_INIT_I,
  input  wire logic       HOST_SELIN_I,
  input  wire logic [7:0] HOST_DATA_I,
  input  wire logic       HOST_DATA_OE_I,
  output logic      [7:0] HOST_DATA_O,
  output logic      [4:0] HOST_STATUS_O,
  // Parallel port pins
  input  wire logic       BUSY_I,
  input  wire logic       ACK_I,
  input  wire logic       PAPER_I,
  input  wire logic       SELECT_I,
  input  wire logic       FAULT_I,
  output logic            STROBE_O,
  output logic            LINEFD_O,
  output logic            INIT_O,
  output logic            SELIN_O,
  input  wire logic [7:0] PDATA_I,
  output logic      [7:0] PDATA_O,
  output logic            PDATA_OE_O
);

  logic       port_owner_select; // 1: host owns pins, 0: microcontroller
  logic [7:0] ctl;               // Control register storage
  logic [7:0] dat;               // Data register storage
  logic [4:0] st_s1, st_s2, st_s3; // Status pin synchronisers
  logic [7:0] pd_s1, pd_s2, pd_s3; // Data pin synchronisers
  logic [4:0] st_live;           // Settled status pins {busy,ack,pe,sel,flt}
  logic [7:0] pd_live;           // Settled data pins
  logic       mcu_owns;          // Microcontroller has the pins
  logic       data_drive;        // Microcontroller drives data pins
  logic [7:0] next_rdata;        // Read mux result

  assign mcu_owns   = ~port_owner_select;
  assign data_drive = mcu_owns & ~ctl[mppt_pkg::CT_DIR];

  // Pin inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      st_s1 <= 5'h00;
      st_s2 <= 5'h00;
      st_s3 <= 5'h00;
      pd_s1 <= 8'h00;
      pd_s2 <= 8'h00;
      pd_s3 <= 8'h00;
    end else begin
      st_s1 <= {BUSY_I, ACK_I, PAPER_I, SELECT_I, FAULT_I};
      st_s2 <= st_s1;
      st_s3 <= st_s2;
      pd_s1 <= PDATA_I;
      pd_s2 <= pd_s1;
      pd_s3 <= pd_s2;
    end
  end

  // Filtered levels, updated bit by bit when the last two stages agree
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      st_live <= 5'h00;
      pd_live <= 8'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (st_s2[i] == st_s3[i]) st_live[i] <= st_s3[i];
      end
      for (int i = 0; i < 8; i++) begin
        if (pd_s2[i] == pd_s3[i]) pd_live[i] <= pd_s3[i];
      end
    end
  end

  // Owner select, only writable status bit
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      port_owner_select <= mppt_pkg::RST_STATUS[mppt_pkg::ST_OWNER];
    end else if (WR_I && ADDR_I == mppt_pkg::ADDR_STATUS) begin
      port_owner_select <= WDATA_I[mppt_pkg::ST_OWNER];
    end
  end

  // Control register; unused bits never stored so they read zero
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ctl <= mppt_pkg::RST_CONTROL;
    end else if (WR_I && ADDR_I == mppt_pkg::ADDR_CONTROL) begin
      ctl <= WDATA_I & mppt_pkg::CT_MASK;
    end
  end

  // Data register, written value drives the pins while the microcontroller owns them and CT_DIR is clear
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      dat <= mppt_pkg::RST_DATA;
    end else if (WR_I && ADDR_I == mppt_pkg::ADDR_DATA) begin
      dat <= WDATA_I;
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 8'h00;
    unique case (ADDR_I)
      mppt_pkg::ADDR_STATUS: begin
        next_rdata[mppt_pkg::ST_BUSY]   = ~st_live[4];
        next_rdata[mppt_pkg::ST_ACK]    = st_live[3];
        next_rdata[mppt_pkg::ST_PAPER]  = st_live[2];
        next_rdata[mppt_pkg::ST_SELECT] = st_live[1];
        next_rdata[mppt_pkg::ST_FAULT]  = st_live[0];
        next_rdata[mppt_pkg::ST_OWNER]  = port_owner_select;
      end
      mppt_pkg::ADDR_CONTROL: next_rdata = ctl;
      mppt_pkg::ADDR_DATA: begin
        // Live pins while owned; otherwise the stored value
        next_rdata = mcu_owns ? pd_live : dat;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data registered: valid the cycle after RD_I
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) RDATA_O <= 8'h00;
    else if (RD_I) RDATA_O <= next_rdata;
  end

  // Output multiplexer between host logic and registers
  always_comb begin
    if (mcu_owns) begin
      STROBE_O   = ~ctl[mppt_pkg::CT_STROBE];
      LINEFD_O   = ~ctl[mppt_pkg::CT_LINEFD];
      SELIN_O    = ~ctl[mppt_pkg::CT_SELIN];
      INIT_O     = ctl[mppt_pkg::CT_INIT];
      PDATA_O    = dat;
      PDATA_OE_O = data_drive;
    end else begin
      STROBE_O   = HOST_STROBE_I;
      LINEFD_O   = HOST_LINEFD_I;
      SELIN_O    = HOST_SELIN_I;
      INIT_O     = HOST_INIT_I;
      PDATA_O    = HOST_DATA_I;
      PDATA_OE_O = HOST_DATA_OE_I;
    end
  end

  // Host sees pin levels only when it owns the port
  assign HOST_DATA_O   = port_owner_select ? pd_live : 8'h00;
  assign HOST_STATUS_O = port_owner_select ? st_live : 5'h00;

  // Assertions
  chk_owner_reset: assert property (@(posedge CLK_I)
    !NRST_I |=> !port_owner_select)
    else $error("owner select not zero after reset");

  chk_host_cut_off: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) mcu_owns |-> HOST_DATA_O == 8'h00)
    else $error("host still sees pins");

  chk_busy_invert: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) (RD_I && ADDR_I == mppt_pkg::ADDR_STATUS)
    |=> RDATA_O[7] == ~$past(st_live[4]))
    else $error("busy bit not inverted");

  chk_status_low: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) (RD_I && ADDR_I == mppt_pkg::ADDR_STATUS)
    |=> RDATA_O[2:1] == 2'h0 && RDATA_O[6:3] == $past(st_live[3:0]))
    else $error("status pins misread");

  chk_strobe_inv: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) mcu_owns |-> STROBE_O == ~ctl[0]
    && LINEFD_O == ~ctl[1] && SELIN_O == ~ctl[3])
    else $error("control outputs not inverted");

  chk_init_pass: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) mcu_owns |-> INIT_O == ctl[2])
    else $error("initialize output wrong");

  chk_dir_release: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) (mcu_owns && ctl[5]) |-> !PDATA_OE_O)
    else $error("data pins driven while input");

  sequence data_write_s;
    WR_I && ADDR_I == mppt_pkg::ADDR_DATA;
  endsequence
  chk_data_shown: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) (data_write_s ##1 data_drive)
    |-> PDATA_O == $past(WDATA_I) && PDATA_OE_O)
    else $error("written data not on pins");

  chk_data_live: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) (RD_I && ADDR_I == mppt_pkg::ADDR_DATA
    && mcu_owns) |=> RDATA_O == $past(pd_live))
    else $error("data read not live");

  chk_ctl_zero: assert property (@(posedge CLK_I)
    disable iff (!NRST_I) (ctl & ~mppt_pkg::CT_MASK) == 8'h00)
    else $error("unused control bits set");

endmodule : mppt_top
`default_nettype wire

/* sim/mppt_periph.sv */
// Parallel port peripheral model at the far side of the pin mux
`timescale 1ns/1ps
`default_nettype none
module mppt_periph (
  // From the device pins
  input  wire logic [7:0] pdata_o_i,
  input  wire logic       pdata_oe_i,
  // Levels the peripheral presents
  input  wire logic [4:0] stat_i,
  input  wire logic [7:0] drv_i,
  // Resolved pin levels
  output logic      [4:0] stat_o,
  output logic      [7:0] pdata_o
);
  // Status pins {busy,ack,paper,select,fault}, always driven
  assign stat_o = stat_i;
  // Peripheral takes the bus only once the device lets go, so no contention
  assign pdata_o = pdata_oe_i ? pdata_o_i : drv_i;
endmodule : mppt_periph
`default_nettype wire

/* sim/mppt_top_bench.sv */
// Self-checking bench for the pin takeover multiplexer
`timescale 1ns/1ps
`default_nettype none
module mppt_top_bench;
  logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, hdata = 8'hA5, drv = 8'h3C;
  logic [7:0]  rdata, pd_o, pd_i, v, c, h_dat;
  logic [3:0]  hctl = 4'hA;           // Host {strobe,linefd,init,selin}
  logic [4:0]  st = 5'h00, st_pin, h_st; // {busy,ack,paper,select,fault}
  logic        stb, lf, ini, sel, oe, hoe = 1'b1;
  int          err_total = 0, n_checks = 0, cyc = 0;
  // Clock, 25 ns period
  initial forever #12.5 clk = ~clk;
  mppt_top dut (.CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WR_I(wr),
    .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata), .HOST_STROBE_I(hctl[3]),
    .HOST_LINEFD_I(hctl[2]), .HOST_INIT_I(hctl[1]), .HOST_SELIN_I(hctl[0]),
    .HOST_DATA_I(hdata), .HOST_DATA_OE_I(hoe), .HOST_DATA_O(h_dat),
    .HOST_STATUS_O(h_st), .BUSY_I(st_pin[4]), .ACK_I(st_pin[3]),
    .PAPER_I(st_pin[2]), .SELECT_I(st_pin[1]), .FAULT_I(st_pin[0]),
    .STROBE_O(stb), .LINEFD_O(lf), .INIT_O(ini), .SELIN_O(sel),
    .PDATA_I(pd_i), .PDATA_O(pd_o), .PDATA_OE_O(oe));
  mppt_periph far (.pdata_o_i(pd_o), .pdata_oe_i(oe), .stat_i(st),
    .drv_i(drv), .stat_o(st_pin), .pdata_o(pd_i));
  // Compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One write strobe, held across one sampling edge
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #2 wr = 1'b0;
  endtask : wr_reg
  // One read strobe; registered data taken after the answering edge
  task rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    #2 addr = a;
    rd = 1'b1;
    @(posedge clk);
    #2 rd = 1'b0;
    d = rdata;
  endtask : rd_reg
  // Verdict and end of run
  task results;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #2 nrst = 1'b1;
    // Reset state: microcontroller owns, control and data clear, status reads 80 (busy inverted)
    rd_reg(mppt_pkg::ADDR_STATUS, v);
    chk(v, 8'h80);
    rd_reg(mppt_pkg::ADDR_CONTROL, v);
    chk(v, 8'h00);
    rd_reg(mppt_pkg::ADDR_DATA, v);
    chk(v, 8'h00);
    chk({3'h0, oe, stb, lf, ini, sel}, 8'h1D);
    chk(h_dat, 8'h00);
    $display("Test reset done");
    // Written data appears on the pins; read-back comes in the control test
    wr_reg(mppt_pkg::ADDR_DATA, 8'h5A);
    chk(pd_o, 8'h5A);
    // Control patterns: dead bits, pin polarity, bus direction
    for (int i = 0; i < 2; i++) begin
      c = i ? 8'h2A : 8'hD5;
      wr_reg(mppt_pkg::ADDR_CONTROL, c);
      rd_reg(mppt_pkg::ADDR_CONTROL, v);
      chk(v, c & 8'h2F);
      chk({3'h0, oe, stb, lf, ini, sel},
          {3'h0, ~c[5], ~c[0], ~c[1], c[2], ~c[3]});
      // A turned-around bus needs the pin filter's latency to show
      repeat (4) @(posedge clk);
      rd_reg(mppt_pkg::ADDR_DATA, v);
      chk(v, c[5] ? drv : 8'h5A);
    end
    $display("Test control done");
    // Walking one over the status pins, then all low
    for (int i = 0; i < 6; i++) begin
      st = 5'h01 << i;
      repeat (6) @(posedge clk);
      rd_reg(mppt_pkg::ADDR_STATUS, v);
      chk(v, {~st[4], st[3:0], 3'h0});
    end
    $display("Test status done");
    // Host takes the pins; read-only bits ignore the write
    wr_reg(mppt_pkg::ADDR_STATUS, 8'hFF);
    rd_reg(mppt_pkg::ADDR_STATUS, v);
    chk(v, 8'h81);
    chk({4'h0, stb, lf, ini, sel}, {4'h0, hctl});
    chk(pd_o, hdata);
    chk({7'h0, oe}, {7'h0, hoe});
    // Host taps follow the settled pins; data read gives stored value
    st = 5'h15;
    repeat (6) @(posedge clk);
    chk(h_dat, hdata);
    chk({3'h0, h_st}, {3'h0, st});
    rd_reg(mppt_pkg::ADDR_DATA, v);
    chk(v, 8'h5A);
    wr_reg(mppt_pkg::ADDR_STATUS, 8'h00);
    chk({4'h0, stb, lf, ini, sel}, 8'h08);
    chk(h_dat, 8'h00);
    chk({3'h0, h_st}, 8'h00);
    // Unmapped place reads zero
    rd_reg(16'h7F3D, v);
    chk(v, 8'h00);
    $display("Test ownership done");
    results();
  end
endmodule : mppt_top_bench
`default_nettype wire
